// *** hdl/twst_map.vh ***
// Purpose: Constants for the two-wire slave transmitter status block.
// Assumes: Included by the block's design file only.
// Notes:   Status codes sit in bits 7..3 of the status byte, prescaler in 1..0.
`ifndef TWST_MAP_VH
`define TWST_MAP_VH
`define TWST_ST_SLA_R      8'ha8
`define TWST_ST_ARB_SLA_R  8'hb0
`define TWST_ST_DATA_ACK   8'hb8
`define TWST_ST_DATA_NACK  8'hc0
`define TWST_ST_LAST_ACK   8'hc8
`define TWST_ST_IDLE       8'hf8
`define TWST_ST_BUS_ERR    8'h00
`define TWST_STATUS_MSB    7
`define TWST_STATUS_LSB    3
`define TWST_PRESC_MSB     1
`define TWST_PRESC_LSB     0
`define TWST_STATUS_RST    5'h1f
`define TWST_BYTE_RST      8'hff
`define TWST_GC_ADDR       7'h00
`define TWST_BITS_PER_BYTE 4'h8
`endif

// *** hdl/twst_slave_tx.v ***
// Purpose: Slave transmitter, end-of-transfer, bus error and address wake logic of a
//          byte-oriented two-wire interface.
// Assumes: SCL and SDA are slow against core_clk_i and are sampled through two
//          flip-flops; software acts through the plain control ports.
// Notes:   Master-side bit timing lives elsewhere; a queued START is a request pulse.
// Operation
// - Deep sleep still acknowledges own or general address
// - After sleep match, hold SCL until flag clear
// - Byte buffer undefined after sleep wake
// - Arbitration lost then addressed reports b0
// - Data byte acknowledged gives status b8
// - Ack enable chooses last byte or more
// - Data byte not acknowledged gives status c0
// - Last byte acknowledged gives status c8
// - End states go to not addressed mode
// - Start request queues START when bus free
// - Flag clear means status reads f8
// - Misplaced START or STOP is bus error
// - Stop request plus flag clears bus error
// - Master uses repeated START to turn direction
// - Status in 7..3, prescaler in 1..0
// - SCL stretched while flag is set
// - Interrupt follows flag and both enables
// - Not addressed slave leaves SDA released
`timescale 1ns/1ps
`include "twst_map.vh"
module twst_slave_tx (
  input  wire       core_clk_i,
  input  wire       rst_b_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        scl_o,
  output reg        scl_oe_o,
  output reg        sda_o,
  output reg        sda_oe_o,
  input  wire [6:0] slave_address_field_i,
  input  wire       general_call_enable_i,
  input  wire       ack_enable_bit_i,
  input  wire       start_request_bit_i,
  input  wire       stop_request_bit_i,
  input  wire       job_done_write_i,
  input  wire       irq_enable_bit_i,
  input  wire       global_irq_enable_i,
  input  wire       arb_lost_i,
  input  wire       deep_sleep_i,
  input  wire [1:0] prescaler_field_i,
  input  wire [7:0] tx_byte_i,
  input  wire       tx_valid_i,
  output reg        tx_ready_o,
  output reg        job_done_flag_o,
  output reg  [7:0] status_reg_o,
  output reg        irq_o,
  output reg        wake_o,
  output reg        start_issue_o,
  output reg        stop_request_bit_o
);
  // Internal states of the slave engine.
  localparam [2:0] S_UNADDR = 3'h0;
  localparam [2:0] S_ADDR   = 3'h1;
  localparam [2:0] S_AACK   = 3'h2;
  localparam [2:0] S_TXBIT  = 3'h3;
  localparam [2:0] S_RACK   = 3'h4;
  localparam [2:0] S_WAIT   = 3'h5;
  localparam [2:0] S_IGNORE = 3'h6;

  // Full status bytes; code_reg keeps only bits 7..3 of each, taken by part-select.
  localparam [7:0] ST_SLA_R     = `TWST_ST_SLA_R;
  localparam [7:0] ST_ARB_SLA_R = `TWST_ST_ARB_SLA_R;
  localparam [7:0] ST_DATA_ACK  = `TWST_ST_DATA_ACK;
  localparam [7:0] ST_DATA_NACK = `TWST_ST_DATA_NACK;
  localparam [7:0] ST_LAST_ACK  = `TWST_ST_LAST_ACK;
  localparam [7:0] ST_BUS_ERR   = `TWST_ST_BUS_ERR;

  reg [1:0] scl_sync_reg;
  reg [1:0] sda_sync_reg;
  reg       scl_d_reg;
  reg       sda_d_reg;
  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [4:0] code_reg;
  reg       last_byte_reg;
  reg       busy_reg;
  reg       start_pend_reg;
  reg       slept_reg;
  reg       is_master_reg;
  // Two-entry buffer feeding byte_buffer_reg.
  reg [7:0] buf_mem [0:1];
  reg       wr_ptr_reg;
  reg       rd_ptr_reg;
  reg [1:0] cnt_reg;
  reg [7:0] byte_buffer_reg;

  wire scl_s    = scl_sync_reg[1];
  wire sda_s    = sda_sync_reg[1];
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire in_frame = (state_reg != S_UNADDR) && (state_reg != S_WAIT) &&
                  (state_reg != S_IGNORE);
  wire own_hit  = (shift_reg[7:1] == slave_address_field_i);
  wire gc_hit   = (shift_reg[7:1] == `TWST_GC_ADDR) & general_call_enable_i;
  wire addr_ok  = ack_enable_bit_i & shift_reg[0] & (own_hit | gc_hit);
  wire buf_pop  = job_done_flag_o & job_done_write_i & (cnt_reg != 2'h0);
  wire buf_push = tx_valid_i & (cnt_reg != 2'h2);

  // Pin synchronisers and one-cycle delayed copies for edge finding.
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_d_reg    <= scl_s;
      sda_d_reg    <= sda_s;
    end
  end

  // Byte buffer: software pushes words, a flag release pops one into byte_buffer_reg.
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg      <= 1'b0;
      rd_ptr_reg      <= 1'b0;
      cnt_reg         <= 2'h0;
      tx_ready_o      <= 1'b1;
      byte_buffer_reg <= `TWST_BYTE_RST;
    end else begin
      if (buf_push) begin
        buf_mem[wr_ptr_reg] <= tx_byte_i;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (buf_pop) begin
        byte_buffer_reg <= buf_mem[rd_ptr_reg];
        rd_ptr_reg      <= ~rd_ptr_reg;
      end
      cnt_reg    <= cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
      tx_ready_o <= ((cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop}) != 2'h2);
    end
  end

  // How the slave engine moves between its states.
  // S_UNADDR is the resting state: the engine watches the bus for a START.
  // A START with the flag clear moves the engine to S_ADDR.
  // In S_ADDR eight rising SCL edges shift the address and direction bit in.
  // On the falling edge after the eighth bit the address is judged.
  // A match with read direction and ack enable set pulls SDA low in S_AACK.
  // Any other address sends the engine back to S_UNADDR without a word.
  // The falling edge after the acknowledge raises the flag and parks in S_WAIT.
  // In S_WAIT the flag is up and SCL is held low by the stretch logic.
  // A flag write in S_WAIT after an address or an acknowledged byte loads the
  // next byte and enters S_TXBIT.
  // A flag write in S_WAIT after a last byte or a refused byte ends the
  // transfer: the engine drops to S_UNADDR and lets SDA go.
  // S_TXBIT puts one bit on SDA for each SCL low phase, MSB first.
  // The bit changes only after a falling SCL edge seen through the
  // synchroniser, so SDA never moves while SCL is high.
  // After eight bits S_RACK releases SDA and samples the master's answer on
  // the next rising SCL edge.
  // The answer and the last-byte mark together pick the next status code.
  // S_IGNORE is entered on a bus error and stays there until recovery.
  //
  // Bus errors.
  // A START or STOP inside an address, data or acknowledge bit is illegal.
  // The only START that is legal inside S_ADDR is one at bit count zero,
  // which is how a repeated START restarts the address phase.
  // On a bus error the engine lets go of SDA at once, so a confused master
  // cannot be held up by a stale data bit.
  // Recovery needs the stop request together with the flag write; a flag
  // write alone leaves the engine in S_IGNORE with the error code kept.
  // Recovery never sends a STOP; it only returns the engine to rest.
  //
  // Clock stretching.
  // The stretch logic only pulls SCL low once SCL has been seen low, so a
  // flag raised while SCL is high does not cut a high phase short.
  // Once pulled, SCL stays low until the flag is cleared by software.
  // A long software reaction therefore blocks the bus for every device on it;
  // this is the price of never losing a byte.
  //
  // Sleep.
  // The address match runs off SCL edges found in the sampled pins, so a
  // matching address is acknowledged even with deep sleep requested.
  // The wake output then stays up until the flag is cleared.
  // The byte buffer is not refreshed from the bus on such a wake, so its
  // content must not be trusted for the byte that woke the block.
  //
  // Queued START.
  // A start request given with the flag write in an end state is remembered.
  // The request fires as a one-cycle pulse once a STOP has marked the bus
  // free and no new START is being seen in the same cycle.
  //
  // Status output.
  // The status byte is registered: the code sits in bits 7..3, bit 2 is zero
  // and the prescaler field is echoed in bits 1..0.
  // While the flag is clear the code reads as all ones, so software polling
  // between states never sees a stale code.
  //
  // Byte buffer.
  // A flag write in S_WAIT pops the oldest word straight into the shifter.
  // If software pushed nothing, the previous byte is sent again.
  //
  // Slave engine, status and flag handling.
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg          <= S_UNADDR;
      bit_cnt_reg        <= 4'h0;
      shift_reg          <= 8'h00;
      code_reg           <= `TWST_STATUS_RST;
      last_byte_reg      <= 1'b0;
      busy_reg           <= 1'b0;
      start_pend_reg     <= 1'b0;
      slept_reg          <= 1'b0;
      is_master_reg      <= 1'b0;
      job_done_flag_o    <= 1'b0;
      stop_request_bit_o <= 1'b0;
      start_issue_o      <= 1'b0;
      wake_o             <= 1'b0;
      sda_o              <= 1'b0;
      sda_oe_o           <= 1'b0;
      scl_o              <= 1'b0;
      scl_oe_o           <= 1'b0;
      status_reg_o       <= {`TWST_STATUS_RST, 3'h0};
      irq_o              <= 1'b0;
    end else begin
      start_issue_o <= 1'b0;
      if (arb_lost_i)
        is_master_reg <= 1'b1;
      // Bus busy tracking for the queued START.
      if (start_c)
        busy_reg <= 1'b1;
      else if (stop_c)
        busy_reg <= 1'b0;
      if (start_pend_reg && !busy_reg && !start_c) begin
        start_issue_o  <= 1'b1;
        start_pend_reg <= 1'b0;
      end
      // Software release of the flag picks the next action.
      if (job_done_flag_o && job_done_write_i) begin
        job_done_flag_o <= 1'b0;
        wake_o          <= 1'b0;
        slept_reg       <= 1'b0;
        if (code_reg == ST_BUS_ERR[7:3]) begin
          if (stop_request_bit_i) begin
            stop_request_bit_o <= 1'b0;
            state_reg          <= S_UNADDR;
            sda_oe_o           <= 1'b0;
          end
        end else if (state_reg == S_WAIT && code_reg != ST_DATA_NACK[7:3] &&
                     code_reg != ST_LAST_ACK[7:3]) begin
          // Next byte goes out; ack enable decides whether it is the last.
          shift_reg     <= buf_pop ? buf_mem[rd_ptr_reg] : byte_buffer_reg;
          last_byte_reg <= ~ack_enable_bit_i;
          bit_cnt_reg   <= 4'h0;
          state_reg     <= S_TXBIT;
        end else begin
          state_reg <= S_UNADDR;
          sda_oe_o  <= 1'b0;
          if (start_request_bit_i)
            start_pend_reg <= 1'b1;
        end
      end else if ((start_c || stop_c) && in_frame && (state_reg != S_ADDR || bit_cnt_reg != 4'h0)) begin
        job_done_flag_o    <= 1'b1;
        code_reg           <= ST_BUS_ERR[7:3];
        stop_request_bit_o <= 1'b0;
        state_reg          <= S_IGNORE;
        sda_oe_o           <= 1'b0;
      end else if (start_c && !job_done_flag_o && state_reg != S_IGNORE) begin
        // Repeated or fresh START: listen for an address.
        state_reg   <= S_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_o    <= 1'b0;
      end else begin
        case (state_reg)
          S_ADDR: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == `TWST_BITS_PER_BYTE) begin
              if (addr_ok) begin
                // Acknowledge works in deep sleep too: it runs off SCL edges.
                sda_o     <= 1'b0;
                sda_oe_o  <= 1'b1;
                state_reg <= S_AACK;
                slept_reg <= deep_sleep_i;
              end else begin
                state_reg <= S_UNADDR;
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              sda_oe_o        <= 1'b0;
              job_done_flag_o <= 1'b1;
              wake_o          <= slept_reg;
              // Buffer content is not refreshed from the bus on a sleep wake.
              code_reg        <= is_master_reg ? ST_ARB_SLA_R[7:3]
                                               : ST_SLA_R[7:3];
              is_master_reg   <= 1'b0;
              state_reg       <= S_WAIT;
            end
          end
          S_TXBIT: begin
            sda_o    <= 1'b0;
            sda_oe_o <= ~shift_reg[7];
            if (scl_fall) begin
              shift_reg   <= {shift_reg[6:0], 1'b1};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == `TWST_BITS_PER_BYTE - 4'h1) begin
                state_reg <= S_RACK;
              end
            end
          end
          S_RACK: begin
            sda_oe_o <= 1'b0;
            if (scl_rise) begin
              job_done_flag_o <= 1'b1;
              state_reg       <= S_WAIT;
              if (sda_s)
                code_reg <= ST_DATA_NACK[7:3];
              else if (last_byte_reg)
                code_reg <= ST_LAST_ACK[7:3];
              else
                code_reg <= ST_DATA_ACK[7:3];
            end
          end
          default: begin
          end
        endcase
      end
      // SCL held low on every falling edge seen while the flag is up.
      scl_o    <= 1'b0;
      scl_oe_o <= job_done_flag_o & (~scl_s | scl_oe_o);
      // Status shows f8 whenever the flag is clear.
      status_reg_o <= {(job_done_flag_o ? code_reg : `TWST_STATUS_RST), 1'b0,
                       prescaler_field_i};
      irq_o <= job_done_flag_o & irq_enable_bit_i & global_irq_enable_i;
      if (stop_request_bit_i && !job_done_write_i)
        stop_request_bit_o <= 1'b1;
    end
  end
endmodule

// *** bench/twst_chk.sv ***
// Purpose: Port-level checks of the two-wire slave transmitter status block.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes:   Attached to the design by bind.
`timescale 1ns/1ps
module twst_chk (
  input logic       core_clk_i,
  input logic       rst_b_i,
  input logic       scl_i,
  input logic       job_done_write_i,
  input logic       stop_request_bit_i,
  input logic       irq_enable_bit_i,
  input logic       global_irq_enable_i,
  input logic       deep_sleep_i,
  input logic [1:0] prescaler_field_i,
  input logic       scl_oe_o,
  input logic       sda_oe_o,
  input logic       job_done_flag_o,
  input logic [7:0] status_reg_o,
  input logic       irq_o,
  input logic       wake_o,
  input logic       start_issue_o,
  input logic       stop_request_bit_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic irq_q;
  // Expected interrupt level, one cycle behind the flag and both enables.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) irq_q <= 1'b0;
    else irq_q <= job_done_flag_o & irq_enable_bit_i & global_irq_enable_i;
  end
  sequence flag_write;
    job_done_flag_o && job_done_write_i;
  endsequence
  sequence flag_idle;
    !job_done_flag_o [*2];
  endsequence
  AST_IDLE_CODE: assert property (flag_idle |-> status_reg_o[7:2] == 6'h3e)
    else $error("status not f8 while flag clear");
  AST_PRESC: assert property ($past(rst_b_i) |-> status_reg_o[2:0] == {1'b0, $past(prescaler_field_i)})
    else $error("prescaler bits not echoed");
  AST_IRQ: assert property (irq_o == irq_q)
    else $error("interrupt level wrong");
  AST_CLEAR: assert property (flag_write |=> !job_done_flag_o)
    else $error("flag write did not clear flag");
  AST_STRETCH: assert property ((job_done_flag_o && !scl_i) [*5] |-> scl_oe_o)
    else $error("clock not stretched while flag set");
  AST_RECOVER: assert property (flag_write ##0 (status_reg_o[7:3] == 5'h00 && stop_request_bit_i)
    |-> ##[1:3] (!stop_request_bit_o && !scl_oe_o && !sda_oe_o))
    else $error("bus error recovery did not release");
  AST_END_RELEASE: assert property (flag_write ##0 status_reg_o[7:4] == 4'hc |=> !sda_oe_o [*8])
    else $error("data line driven after last byte");
  AST_START_PULSE: assert property (start_issue_o |=> !start_issue_o)
    else $error("start request longer than one cycle");
  AST_WAKE_SLEEP: assert property ($rose(wake_o) |-> $past(deep_sleep_i))
    else $error("wake without sleep");
  AST_WAKE_HOLD: assert property ($rose(wake_o) |-> ##[0:20] (job_done_flag_o && scl_oe_o))
    else $error("wake did not hold the clock");
endmodule
bind twst_slave_tx twst_chk chk (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i),
  .job_done_write_i(job_done_write_i), .stop_request_bit_i(stop_request_bit_i),
  .irq_enable_bit_i(irq_enable_bit_i), .global_irq_enable_i(global_irq_enable_i),
  .deep_sleep_i(deep_sleep_i), .prescaler_field_i(prescaler_field_i), .scl_oe_o(scl_oe_o),
  .sda_oe_o(sda_oe_o), .job_done_flag_o(job_done_flag_o), .status_reg_o(status_reg_o),
  .irq_o(irq_o), .wake_o(wake_o), .start_issue_o(start_issue_o),
  .stop_request_bit_o(stop_request_bit_o));

// *** bench/twst_bus_master.sv ***
// Purpose: Behavioural two-wire bus master that reads from the slave.
// Assumes: Both lines have pull-ups; a released line reads high.
// Notes:   half() is four core clocks, 200 ns; an unstretched bit takes 13 clocks, so 650 ns.
`timescale 1ns/1ps
module twst_bus_master (
  input  logic core_clk_i,
  input  logic scl_line_i,
  input  logic sda_line_i,
  output logic m_scl_o = 1'b1,
  output logic m_sda_o = 1'b1
);
  // Half a bit period of the bus clock.
  task automatic half();
    repeat (4) @(posedge core_clk_i);
  endtask
  // Releases SCL and waits, bounded, while the slave stretches it low.
  task automatic rise();
    m_scl_o <= 1'b1;
    half();
    for (int i = 0; i < 4000 && scl_line_i !== 1'b1; i++) @(posedge core_clk_i);
  endtask
  // Moves n bits MSB first; a one in w releases SDA so the slave may drive it.
  task automatic xfer(input logic [8:0] w, output logic [8:0] r, input int n = 9);
    for (int i = 8; i > 8 - n; i--) begin
      @(posedge core_clk_i);
      m_sda_o <= w[i];
      half();
      rise();
      r[i] = sda_line_i;
      half();
      m_scl_o <= 1'b0;
    end
  endtask
  // Start, or repeated start when SCL is low, so the master keeps the bus.
  task automatic start_cond();
    @(posedge core_clk_i);
    m_sda_o <= 1'b1;
    half();
    rise();
    m_sda_o <= 1'b0;
    half();
    m_scl_o <= 1'b0;
  endtask
  // Stop condition, leaving both lines released.
  task automatic stop_cond();
    @(posedge core_clk_i);
    m_sda_o <= 1'b0;
    half();
    rise();
    m_sda_o <= 1'b1;
    half();
  endtask
endmodule

// *** bench/tb_top.sv ***
// Purpose: Self-checking bench for the slave transmitter status block.
// Assumes: The master model drives SCL and SDA against the open-drain slave.
// Notes:   Random data, prescaler and interrupt enable come from a fixed seed.
`timescale 1ns/1ps
module tb_top;
  logic       core_clk_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       m_scl, m_sda, scl_oe, sda_oe, flag, irq, wake, stq, stop_request_column, txr;
  logic [7:0] status, d0, d1, tx_byte = 8'h00;
  logic [6:0] own = 7'h2d;
  logic [1:0] presc = 2'b00;
  logic       ack_en = 1'b1, start_request_column = 1'b0, sto_req = 1'b0, wr = 1'b0, arb = 1'b0;
  logic       sleep = 1'b0, txv = 1'b0, ien = 1'b0;
  logic [8:0] rd;
  int         n_fail = 0, comparisons = 0, cyc = 0;
  wire        scl = m_scl & ~scl_oe;
  wire        sda = m_sda & ~sda_oe;
  always #25 core_clk_i = ~core_clk_i;
  // Cuts a hung run short.
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      wrap_up();
    end
  end
  twst_bus_master bm (.core_clk_i(core_clk_i), .scl_line_i(scl), .sda_line_i(sda),
    .m_scl_o(m_scl), .m_sda_o(m_sda));
  twst_slave_tx uut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda),
    .scl_o(), .scl_oe_o(scl_oe), .sda_o(), .sda_oe_o(sda_oe), .slave_address_field_i(own),
    .general_call_enable_i(1'b0), .ack_enable_bit_i(ack_en), .start_request_bit_i(start_request_column),
    .stop_request_bit_i(sto_req), .job_done_write_i(wr), .irq_enable_bit_i(ien),
    .global_irq_enable_i(1'b1), .arb_lost_i(arb), .deep_sleep_i(sleep),
    .prescaler_field_i(presc), .tx_byte_i(tx_byte), .tx_valid_i(txv), .tx_ready_o(txr),
    .job_done_flag_o(flag), .status_reg_o(status), .irq_o(irq), .wake_o(wake),
    .start_issue_o(stq), .stop_request_bit_o(stop_request_column));
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits for the flag, then checks the status code once it has settled.
  task automatic wait_code(input logic [4:0] code);
    for (int i = 0; i < 3000 && flag !== 1'b1; i++) @(negedge core_clk_i);
    repeat (2) @(negedge core_clk_i);
    chk(status, {code, 1'b0, presc});
  endtask
  // Pulses the flag write with the given control levels.
  task automatic release_flag(input logic a, input logic s, input logic p);
    @(posedge core_clk_i);
    ack_en <= a;
    start_request_column <= s;
    sto_req <= p;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
    sto_req <= 1'b0;
  endtask
  // Loads one byte into the transmit buffer.
  task automatic push(input logic [7:0] d);
    @(posedge core_clk_i);
    tx_byte <= d;
    txv <= 1'b1;
    do @(negedge core_clk_i); while (txr !== 1'b1);
    @(posedge core_clk_i);
    txv <= 1'b0;
  endtask
  // Addresses the slave for read, optionally after lost arbitration or from sleep.
  task automatic open_read(input logic a, input logic s, input logic [4:0] code);
    @(posedge core_clk_i);
    presc <= 2'($urandom);
    ien <= 1'($urandom);
    sleep <= s;
    bm.start_cond();
    fork
      bm.xfer({own, 2'b11}, rd);
      if (a) begin
        repeat (12) @(posedge core_clk_i);
        arb <= 1'b1;
        @(posedge core_clk_i);
        arb <= 1'b0;
      end
    join
    chk({7'h00, rd[0]}, 8'h00);
    wait_code(code);
    chk({7'h00, irq}, {7'h00, ien});
    if (s) chk({7'h00, wake}, 8'h01);
    sleep <= 1'b0;
  endtask
  // Releases the flag, reads one byte with the given acknowledge, checks the code.
  task automatic send(input logic [7:0] d, input logic a, input logic nak, input logic [4:0] code);
    release_flag(a, 1'b0, 1'b0);
    bm.xfer({8'hff, nak}, rd);
    chk(rd[8:1], d);
    wait_code(code);
  endtask
  // Leaves an end state, then reads on as the master would.
  task automatic close(input logic s);
    release_flag(1'b1, s, 1'b0);
    repeat (3) @(negedge core_clk_i);
    chk(status, {5'h1f, 1'b0, presc});
    bm.xfer(9'h1ff, rd);
    chk(rd[8:1], 8'hff);
    bm.stop_cond();
  endtask
  task automatic wrap_up();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Main sequence.
  initial begin
    void'($urandom(32'h4584));
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    repeat (20) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(negedge core_clk_i);
    chk(status, 8'hf8);
    chk({6'h00, flag, txr}, 8'h01);
    open_read(1'b0, 1'b0, 5'h15);
    push(d0);
    push(d1);
    @(negedge core_clk_i);
    chk({7'h00, txr}, 8'h00);
    send(d0, 1'b1, 1'b0, 5'h17);
    send(d1, 1'b0, 1'b0, 5'h19);
    close(1'b0);
    open_read(1'b1, 1'b0, 5'h16);
    push(d1);
    send(d1, 1'b0, 1'b1, 5'h18);
    close(1'b1);
    for (int i = 0; i < 100 && stq !== 1'b1; i++) @(negedge core_clk_i);
    chk({7'h00, stq}, 8'h01);
    open_read(1'b0, 1'b1, 5'h15);
    push(d0);
    send(d0, 1'b0, 1'b1, 5'h18);
    close(1'b0);
    bm.start_cond();
    bm.xfer(9'h1ff, rd, 3);
    bm.start_cond();
    wait_code(5'h00);
    release_flag(1'b1, 1'b0, 1'b1);
    repeat (4) @(negedge core_clk_i);
    chk({4'h0, stop_request_column, flag, scl_oe, sda_oe}, 8'h00);
    bm.stop_cond();
    wrap_up();
  end
endmodule
